// ### shared/tpcs_pkg.sv
// package: constants and types for shared timer prescaler and clock select
package tpcs_pkg;
	localparam int unsigned tpcs_clk_hz = 40000000;
	localparam int tpcs_presc_w = 10;
	localparam int tpcs_sel_w = 3;
	localparam logic [2:0] tpcs_sel_stop = 3'h0;
	localparam logic [2:0] tpcs_sel_div1 = 3'h1;
	localparam logic [2:0] tpcs_sel_div8 = 3'h2;
	localparam logic [2:0] tpcs_sel_div64 = 3'h3;
	localparam logic [2:0] tpcs_sel_div256 = 3'h4;
	localparam logic [2:0] tpcs_sel_div1024 = 3'h5;
	localparam logic [2:0] tpcs_sel_ext_fall = 3'h6;
	localparam logic [2:0] tpcs_sel_ext_rise = 3'h7;
	localparam logic [9:0] tpcs_mask_div8 = 10'h007;
	localparam logic [9:0] tpcs_mask_div64 = 10'h03f;
	localparam logic [9:0] tpcs_mask_div256 = 10'h0ff;
	localparam logic [9:0] tpcs_mask_div1024 = 10'h3ff;
	localparam logic [3:0] tpcs_addr_misc = 4'h0;
	localparam logic [3:0] tpcs_addr_sel = 4'h1;
	localparam logic [3:0] tpcs_addr_status = 4'h2;
	localparam int tpcs_psr_bit = 0;
	localparam int tpcs_sel0_lsb = 0;
	localparam int tpcs_sel1_lsb = 4;
	localparam logic [7:0] tpcs_misc_reset = 8'h00;
	localparam logic [7:0] tpcs_misc_wmask = 8'hee;
	localparam logic [31:0] tpcs_unmapped = 32'h00000000;
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} tpcs_req_s;
	typedef struct packed {
		logic div8;
		logic div64;
		logic div256;
		logic div1024;
	} tpcs_taps_s;
endpackage

// ### verilog/tpcs_prescaler.sv
// file: free-running shared prescaler with tick taps
`timescale 1ns/1ps
module tpcs_prescaler
	import tpcs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic presc_clear,
	output tpcs_taps_s taps
);
	logic [tpcs_presc_w-1:0] count;

	// free running; only resetn or the presc_clear pulse restarts it
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			count <= '0;
		else if (presc_clear)
			count <= '0;
		else
			count <= count + 10'h001;
	end

	// one-cycle ticks at each rollover
	always_comb
	begin
		taps.div8 = (count & tpcs_mask_div8) == tpcs_mask_div8;
		taps.div64 = (count & tpcs_mask_div64) == tpcs_mask_div64;
		taps.div256 = (count & tpcs_mask_div256) == tpcs_mask_div256;
		taps.div1024 = (count & tpcs_mask_div1024) == tpcs_mask_div1024;
	end

	property p_tick_period;
		@(posedge clk) disable iff (!resetn)
		(taps.div8 && !presc_clear) |=> !taps.div8 [*7];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("div8 tick too early");

	property p_nest;
		@(posedge clk) disable iff (!resetn)
		taps.div1024 |-> (taps.div256 && taps.div64 && taps.div8);
	endproperty
	a_nest: assert property (p_nest) else $error("taps not nested");

	property p_clear_phase;
		@(posedge clk) disable iff (!resetn)
		presc_clear |=> (count == 10'h000);
	endproperty
	a_clear_phase: assert property (p_clear_phase) else $error("prescaler not cleared");
endmodule

// ### verilog/tpcs_ext_sync.sv
// file: external count pin sampler and edge detector
`timescale 1ns/1ps
module tpcs_ext_sync
	import tpcs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic external_count_pin,
	output logic rise,
	output logic fall
);
	logic latch_q;
	logic sync_q;
	logic edge_q;

	// sampler stage on the high phase, then two rising-edge registers
	always_ff @(negedge clk or negedge resetn)
	begin
		if (!resetn)
			latch_q <= 1'b0;
		else
			latch_q <= external_count_pin;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync_q <= 1'b0;
			edge_q <= 1'b0;
		end
		else
		begin
			sync_q <= latch_q;
			edge_q <= sync_q;
		end
	end

	assign rise = sync_q & ~edge_q;
	assign fall = ~sync_q & edge_q;

	property p_rise_one;
		@(posedge clk) disable iff (!resetn)
		rise |=> !rise;
	endproperty
	a_rise_one: assert property (p_rise_one) else $error("rise pulse longer than one cycle");

	property p_no_both;
		@(posedge clk) disable iff (!resetn)
		!(rise && fall);
	endproperty
	a_no_both: assert property (p_no_both) else $error("rise and fall together");
endmodule

// ### verilog/tpcs_top.sv
// file: shared prescaler, clock select and register slave for two timers
//
// The register addresses and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - one prescaler, independent select per timer
// - select 1 ticks every system clock
// - taps at divide 8, 64, 256, 1024
// - prescaler runs free, untouched by selects
// - first prescaled tick within 1 to N+1
// - prescaler reset restarts phase for both
// - pin sampled by latch then register
// - rising edge at 7, falling at 6
// - pin edge to tick 1.5-2.5 cycles
// - external clock never prescaled
// - writing one resets prescaler, self-clears
// - reset bit always reads zero
// - stop select gives no ticks
// - eight-code clock-select encoding
// - pin counts even when driven as output
module tpcs_top
	import tpcs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic external_count_pin_0,
	input wire logic external_count_pin_1,
	output logic [1:0] timer_tick
);
	tpcs_req_s req;
	tpcs_taps_s taps;
	logic [7:0] misc_special_function_reg;
	logic [2:0] clock_source_select [2];
	logic shared_prescaler_reset_bit;
	logic acked;
	logic [1:0] ext_rise;
	logic [1:0] ext_fall;
	logic [1:0] ext_pin;
	logic [1:0] next_tick;
	logic [1:0] tick_seen;

	assign req.read = avs_read;
	assign req.write = avs_write;
	assign req.address = avs_address;
	assign req.writedata = avs_writedata;
	assign ext_pin = {external_count_pin_1, external_count_pin_0};

	function automatic logic sel_tick(input logic [2:0] sel, input tpcs_taps_s t,
		input logic r, input logic f);
		unique case (sel)
			tpcs_sel_stop: sel_tick = 1'b0;
			tpcs_sel_div1: sel_tick = 1'b1;
			tpcs_sel_div8: sel_tick = t.div8;
			tpcs_sel_div64: sel_tick = t.div64;
			tpcs_sel_div256: sel_tick = t.div256;
			tpcs_sel_div1024: sel_tick = t.div1024;
			tpcs_sel_ext_fall: sel_tick = f;
			tpcs_sel_ext_rise: sel_tick = r;
		endcase
	endfunction

	// one wait cycle per access, answer on the second edge
	assign avs_waitrequest = (req.read | req.write) & ~acked;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			acked <= 1'b0;
		else
			acked <= (req.read | req.write) & ~acked;
	end

	// misc register; bit 0 is the prescaler reset strobe
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			misc_special_function_reg <= tpcs_misc_reset;
			shared_prescaler_reset_bit <= 1'b0;
		end
		else
		begin
			shared_prescaler_reset_bit <= 1'b0;
			if (req.write && !acked && req.address == tpcs_addr_misc)
			begin
				misc_special_function_reg <= req.writedata[7:0] & tpcs_misc_wmask;
				if (req.writedata[tpcs_psr_bit])
					shared_prescaler_reset_bit <= 1'b1;
			end
		end
	end

	// clock-select register, one field per timer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clock_source_select[0] <= tpcs_sel_stop;
			clock_source_select[1] <= tpcs_sel_stop;
		end
		else if (req.write && !acked && req.address == tpcs_addr_sel)
		begin
			clock_source_select[0] <= req.writedata[tpcs_sel0_lsb +: tpcs_sel_w];
			clock_source_select[1] <= req.writedata[tpcs_sel1_lsb +: tpcs_sel_w];
		end
	end

	// sticky record of ticks since last status read
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			tick_seen <= 2'h0;
		else if (req.read && !acked && req.address == tpcs_addr_status)
			tick_seen <= next_tick;
		else
			tick_seen <= tick_seen | next_tick;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			avs_readdata <= tpcs_unmapped;
		else if (req.read && !acked)
		begin
			unique case (req.address)
				tpcs_addr_misc: avs_readdata <= {24'h000000,
					misc_special_function_reg};
				tpcs_addr_sel: avs_readdata <= {25'h0000000, clock_source_select[1],
					1'b0, clock_source_select[0]};
				tpcs_addr_status: avs_readdata <= {30'h00000000, tick_seen};
				default: avs_readdata <= tpcs_unmapped;
			endcase
		end
	end

	tpcs_prescaler u_presc
	(
		.clk(clk),
		.resetn(resetn),
		.presc_clear(shared_prescaler_reset_bit),
		.taps(taps)
	);

	// pin path has no output-enable gate, so driven pins still count
	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_timer
			tpcs_ext_sync u_sync
			(
				.clk(clk),
				.resetn(resetn),
				.external_count_pin(ext_pin[g]),
				.rise(ext_rise[g]),
				.fall(ext_fall[g])
			);
			assign next_tick[g] = sel_tick(clock_source_select[g], taps,
				ext_rise[g], ext_fall[g]);
		end
	endgenerate

	// registered tick gives 1.5 to 2.5 cycles from pin edge
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			timer_tick <= 2'h0;
		else
			timer_tick <= next_tick;
	end

	property p_stop;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[0] == tpcs_sel_stop) |=> !timer_tick[0];
	endproperty
	a_stop: assert property (p_stop) else $error("tick while stopped");

	property p_div1;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[1] == tpcs_sel_div1) |=> timer_tick[1];
	endproperty
	a_div1: assert property (p_div1) else $error("undivided tick missing");

	property p_psr_self_clear;
		@(posedge clk) disable iff (!resetn)
		shared_prescaler_reset_bit |=> !shared_prescaler_reset_bit;
	endproperty
	a_psr_self_clear: assert property (p_psr_self_clear) else $error("reset bit stuck");

	property p_psr_reads_zero;
		@(posedge clk) disable iff (!resetn)
		(avs_read && !avs_waitrequest && avs_address == tpcs_addr_misc) |-> !avs_readdata[0];
	endproperty
	a_psr_reads_zero: assert property (p_psr_reads_zero) else $error("reset bit read one");

	property p_div8_first;
		@(posedge clk) disable iff (!resetn)
		(shared_prescaler_reset_bit && clock_source_select[0] == tpcs_sel_div8
			&& req.address != tpcs_addr_sel)
		|-> ##2 !timer_tick[0] [*7] ##1 timer_tick[0];
	endproperty
	a_div8_first: assert property (p_div8_first)
		else $error("div8 phase after reset wrong");

	property p_ext_rise;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[0] == tpcs_sel_ext_rise && ext_rise[0]
			&& !(req.write && req.address == tpcs_addr_sel)) |=> timer_tick[0];
	endproperty
	a_ext_rise: assert property (p_ext_rise) else $error("rising edge tick missing");

	property p_ext_fall_no_rise;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[1] == tpcs_sel_ext_fall && ext_rise[1]) |=> !timer_tick[1];
	endproperty
	a_ext_fall_no_rise: assert property (p_ext_fall_no_rise)
		else $error("falling mode ticked on rise");

	property p_indep;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[0] == tpcs_sel_stop && clock_source_select[1] == tpcs_sel_div1)
		|=> (timer_tick == 2'h2);
	endproperty
	a_indep: assert property (p_indep) else $error("timers not independent");

	property p_ext_fall;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[1] == tpcs_sel_ext_fall && ext_fall[1]) |=> timer_tick[1];
	endproperty
	a_ext_fall: assert property (p_ext_fall) else $error("falling edge tick missing");

	property p_no_tap_on_ext;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[0] == tpcs_sel_ext_rise && !ext_rise[0]) |=> !timer_tick[0];
	endproperty
	a_no_tap_on_ext: assert property (p_no_tap_on_ext) else $error("tick without pin edge");

	property p_stop_1;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[1] == tpcs_sel_stop) |=> !timer_tick[1];
	endproperty
	a_stop_1: assert property (p_stop_1) else $error("tick while timer 1 stopped");

	property p_div1_0;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[0] == tpcs_sel_div1) |=> timer_tick[0];
	endproperty
	a_div1_0: assert property (p_div1_0) else $error("timer 0 undivided tick missing");

	property p_tap64;
		@(posedge clk) disable iff (!resetn)
		(clock_source_select[1] == tpcs_sel_div64 && taps.div64) |=> timer_tick[1];
	endproperty
	a_tap64: assert property (p_tap64) else $error("div64 tick not passed");

	property p_sel_readback;
		@(posedge clk) disable iff (!resetn)
		(avs_read && !avs_waitrequest && avs_address == tpcs_addr_sel)
		|-> (avs_readdata[tpcs_sel0_lsb +: tpcs_sel_w] == clock_source_select[0]
			&& avs_readdata[tpcs_sel1_lsb +: tpcs_sel_w] == clock_source_select[1]);
	endproperty
	a_sel_readback: assert property (p_sel_readback) else $error("select readback wrong");

	property p_psr_write;
		@(posedge clk) disable iff (!resetn)
		(req.write && !acked && req.address == tpcs_addr_misc && req.writedata[tpcs_psr_bit])
		|=> shared_prescaler_reset_bit;
	endproperty
	a_psr_write: assert property (p_psr_write) else $error("reset bit write lost");

	property p_psr_zero;
		@(posedge clk) disable iff (!resetn)
		(req.write && !acked && req.address == tpcs_addr_misc && !req.writedata[tpcs_psr_bit])
		|=> !shared_prescaler_reset_bit;
	endproperty
	a_psr_zero: assert property (p_psr_zero) else $error("zero write reset prescaler");
endmodule

// ### dv/tpcs_far_side.sv
// far-side model: two timer counters and their external count pins
`timescale 1ns/1ps
module tpcs_far_side
	import tpcs_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [1:0] timer_tick,
	output logic pin_0,
	output logic pin_1,
	output logic [15:0] cnt_0,
	output logic [15:0] cnt_1
);
	// each timer advances once per tick
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_0 <= 16'h0;
			cnt_1 <= 16'h0;
		end
		else
		begin
			cnt_0 <= cnt_0 + 16'(timer_tick[0]);
			cnt_1 <= cnt_1 + 16'(timer_tick[1]);
		end
	end
	initial
	begin
		pin_0 = 1'b0;
		pin_1 = 1'b0;
	end
	// software-driven pulses, each half period several cycles long
	task automatic pulse(input int n, input int hp);
		repeat (n)
		begin
			@(posedge clk);
			pin_0 <= 1'b1;
			pin_1 <= 1'b1;
			repeat (hp) @(posedge clk);
			pin_0 <= 1'b0;
			pin_1 <= 1'b0;
			repeat (hp - 1) @(posedge clk);
		end
	endtask
endmodule

// ### dv/tpcs_top_bench.sv
// self-checking bench for shared prescaler and clock select
`timescale 1ns/1ps
module tpcs_top_bench
	import tpcs_pkg::*;
;
	logic clk, resetn, avs_read, avs_write, avs_waitrequest, pin_0, pin_1;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [1:0] timer_tick;
	logic [15:0] cnt_0, cnt_1;
	logic [31:0] exp_q[$];
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int dv[5] = '{1, 8, 64, 256, 1024};
	tpcs_top uut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.external_count_pin_0(pin_0), .external_count_pin_1(pin_1),
		.timer_tick(timer_tick));
	tpcs_far_side far (.clk(clk), .resetn(resetn), .timer_tick(timer_tick),
		.pin_0(pin_0), .pin_1(pin_1), .cnt_0(cnt_0), .cnt_1(cnt_1));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
		n_tests++;
		if (seen !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, seen);
			miscompares++;
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_read <= rd;
		avs_write <= ~rd;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b1, a, 32'h0);
	endtask
	// tick counts of both timers over a window
	task automatic win(input int w, input int e0, input int e1);
		logic [15:0] a0, a1;
		@(negedge clk);
		a0 = cnt_0;
		a1 = cnt_1;
		repeat (w) @(negedge clk);
		check("ticks_0", 32'(cnt_0 - a0), e0);
		check("ticks_1", 32'(cnt_1 - a1), e1);
	endtask
	// read results compared as they complete
	always @(posedge clk)
	begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			check("readdata", avs_readdata, exp_q.pop_front());
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			miscompares++;
			stop_test();
		end
	end
	initial
	begin
		logic [31:0] v;
		int n, hp;
		void'($urandom(32'h6f4dfd15));
		resetn = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		rd(tpcs_addr_misc, 32'h0);
		rd(tpcs_addr_sel, 32'h0);
		v = $urandom;
		bus(1'b0, tpcs_addr_misc, {v[31:1], 1'b0});
		rd(tpcs_addr_misc, {24'h0, v[7:0] & tpcs_misc_wmask});
		bus(1'b0, 4'h3, v);
		rd(4'h3, tpcs_unmapped);
		win(100, 0, 0);
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b0, tpcs_addr_sel, 32'((5 - i) << 4 | (i + 1)));
			repeat (4) @(posedge clk);
			win(2048, 2048 / dv[i], 2048 / dv[4 - i]);
		end
		// prescaler restart seen by both timers
		bus(1'b0, tpcs_addr_sel, 32'h32);
		repeat (10) @(posedge clk);
		bus(1'b0, tpcs_addr_misc, 32'h1);
		win(60, 7, 0);
		win(10, 1, 1);
		rd(tpcs_addr_misc, 32'h0);
		// external edges; pins steady while modes change
		bus(1'b0, tpcs_addr_sel, 32'h67);
		repeat (4) @(posedge clk);
		n = 1 + $urandom % 8;
		hp = 2 + $urandom % 3;
		fork
			far.pulse(n, hp);
			win(n * 2 * hp + 10, n, n);
		join
		bus(1'b0, tpcs_addr_sel, 32'h10);
		repeat (4) @(posedge clk);
		win(50, 0, 50);
		bus(1'b0, tpcs_addr_sel, 32'h0);
		repeat (5) @(posedge clk);
		rd(tpcs_addr_status, 32'h3);
		rd(tpcs_addr_status, 32'h0);
		stop_test();
	end
endmodule
